// *** common/ttm_map.svh ***
`ifndef TTM_MAP_SVH
`define TTM_MAP_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TTM_OFF_AVGCFG    12'h000
`define TTM_OFF_INT_HI    12'h004
`define TTM_OFF_INT_LO    12'h008
`define TTM_OFF_EXT1_HI   12'h00c
`define TTM_OFF_EXT1_LO   12'h010
`define TTM_OFF_EXT2_HI   12'h014
`define TTM_OFF_EXT2_LO   12'h018
`define TTM_OFF_ENABLES   12'h01c
`define TTM_OFF_STATUS    12'h020
`define TTM_OFF_IRQ_STAT  12'h024
`define TTM_OFF_IRQ_MASK  12'h028
`define TTM_OFF_RESULT0   12'h02c
`define TTM_OFF_RESULT1   12'h030
`define TTM_OFF_RESULT2   12'h034
// ----------------------------------------
// Field positions
// ----------------------------------------
`define TTM_AVG_INT_LSB   0
`define TTM_AVG_EXT1_LSB  2
`define TTM_AVG_EXT2_LSB  4
`define TTM_STAT_LOW_BIT  1
`define TTM_STAT_HIGH_BIT 2
`define TTM_STAT_STRIDE   4
// ----------------------------------------
// Reset values
// ----------------------------------------
`define TTM_RST_AVGCFG    6'h00
`define TTM_RST_HI_LIMIT  12'h7ff
`define TTM_RST_LO_LIMIT  12'h800
`define TTM_RST_ENABLES   3'h0
// ----------------------------------------
// Timing
// ----------------------------------------
`define TTM_MIN_AVG_LOG2  2
`endif

// *** common/ttm_pkg.sv ***
`default_nettype none
package ttm_pkg;
    // One sample offered to the averager
    typedef struct packed {
        logic        valid;
        logic [11:0] temp;
    } ttm_sample_s;

    // One completed average
    typedef struct packed {
        logic        done;
        logic [11:0] temp;
    } ttm_result_s;

    // Bus slave data phase states
    typedef enum logic [0:0] {
        TTM_IDLE = 1'b0,
        TTM_DATA = 1'b1
    } ttm_bus_e;
endpackage
`default_nettype wire

// *** src/ttm_averager.sv ***
`default_nettype none
`include "ttm_map.svh"
module ttm_averager #(
    parameter int unsigned WIDTH = 12,
    parameter int unsigned CNT_W = 5
) (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               enable,
    input  wire logic [1:0]         avg_sel,
    input  wire ttm_pkg::ttm_sample_s sample,
    output ttm_pkg::ttm_result_s    result
);
    import ttm_pkg::*;

    localparam int unsigned ACC_W = WIDTH + CNT_W;

    logic [ACC_W-1:0] acc_q, acc_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    ttm_result_s      res_q, res_d;
    logic [CNT_W-1:0] last_cnt;
    logic [ACC_W-1:0] sum;
    logic [ACC_W-1:0] shifted;

    // ----------------------------------------
    // Accumulate signed samples, divide by shift
    // ----------------------------------------
    always_comb begin
        last_cnt = CNT_W'((32'd1 << (avg_sel + `TTM_MIN_AVG_LOG2)) - 32'd1);
        sum      = acc_q + {{CNT_W{sample.temp[WIDTH-1]}}, sample.temp};
        shifted  = ACC_W'($signed(sum) >>> (avg_sel + `TTM_MIN_AVG_LOG2));
        acc_d    = acc_q;
        cnt_d    = cnt_q;
        res_d    = res_q;
        res_d.done = 1'b0;
        if (!enable) begin
            // Disabled channel drops any partial sum
            acc_d = '0;
            cnt_d = '0;
        end else if (sample.valid) begin
            if (cnt_q >= last_cnt) begin
                // Result only when the full count is in
                res_d.done = 1'b1;
                res_d.temp = shifted[WIDTH-1:0];
                acc_d      = '0;
                cnt_d      = '0;
            end else begin
                acc_d = sum;
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_q <= '0;
            cnt_q <= '0;
            res_q <= '0;
        end else begin
            acc_q <= acc_d;
            cnt_q <= cnt_d;
            res_q <= res_d;
        end
    end

    assign result = res_q;
endmodule
`default_nettype wire

// *** src/ttm_limit_check.sv ***
`default_nettype none
module ttm_limit_check #(
    parameter int unsigned WIDTH = 12
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire ttm_pkg::ttm_result_s result,
    input  wire logic [WIDTH-1:0] high_limit,
    input  wire logic [WIDTH-1:0] low_limit,
    output logic                  over,
    output logic                  under,
    output logic                  eval
);
    import ttm_pkg::*;

    logic over_q, over_d;
    logic under_q, under_d;
    logic eval_q, eval_d;

    // ----------------------------------------
    // Signed compare on each finished average
    // ----------------------------------------
    always_comb begin
        over_d  = over_q;
        under_d = under_q;
        eval_d  = result.done;
        if (result.done) begin
            over_d  = $signed(result.temp) > $signed(high_limit);
            under_d = $signed(result.temp) < $signed(low_limit);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            over_q  <= 1'b0;
            under_q <= 1'b0;
            eval_q  <= 1'b0;
        end else begin
            over_q  <= over_d;
            under_q <= under_d;
            eval_q  <= eval_d;
        end
    end

    assign over  = over_q;
    assign under = under_q;
    assign eval  = eval_q;
endmodule
`default_nettype wire

// *** src/ttm_monitor.sv ***
// Operation
// RULE1: internal averaging count from bits 1:0
// RULE2: first external averaging count from bits 3:2
// RULE3: second external averaging count from bits 5:4
// RULE4: internal over high sets status bit 2
// RULE5: internal under low sets status bit 1
// RULE6: first external over high sets bit 2
// RULE7: first external under low sets bit 1
// RULE8: second external over high sets bit 2
// RULE9: second external under low sets bit 1
// RULE10: thresholds signed 12-bit, 0.125 C steps
// RULE11: each channel runs only when enabled
// RULE12: compare only on completed averages
`default_nettype none
`include "ttm_map.svh"
module ttm_monitor #(
    parameter int unsigned WIDTH = 12
) (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic [31:0]               hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire ttm_pkg::ttm_sample_s int_sample,
    input  wire ttm_pkg::ttm_sample_s ext1_sample,
    input  wire ttm_pkg::ttm_sample_s ext2_sample,
    output logic                      irq
);
    import ttm_pkg::*;

    localparam int unsigned NCH = 3;

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [5:0]       avgcfg_q, avgcfg_d;
    logic [WIDTH-1:0] hi_q [NCH];
    logic [WIDTH-1:0] hi_d [NCH];
    logic [WIDTH-1:0] lo_q [NCH];
    logic [WIDTH-1:0] lo_d [NCH];
    logic [NCH-1:0]   en_q, en_d;
    logic [5:0]       istat_q, istat_d;
    logic [5:0]       imask_q, imask_d;
    logic [WIDTH-1:0] last_q [NCH];
    logic [WIDTH-1:0] last_d [NCH];
    logic             irq_q, irq_d;

    // Bus pipeline state
    ttm_bus_e         bst_q, bst_d;
    logic             wr_q, wr_d;
    logic [11:0]      addr_q, addr_d;
    logic [31:0]      rdata_q, rdata_d;

    // Channel wiring
    ttm_sample_s      samp [NCH];
    ttm_result_s      res [NCH];
    logic [NCH-1:0]   over, under, eval;
    logic [NCH-1:0]   over_seen, under_seen;
    logic             addr_ok;
    logic [31:0]      rd_mux;
    logic [11:0]      rd_addr;
    logic [11:0]      status_w;
    logic             wr_dp;

    // ----------------------------------------
    // Sample inputs as a channel array
    // ----------------------------------------
    // Index 0 internal, 1 and 2 external sensors
    assign samp[0] = int_sample;
    assign samp[1] = ext1_sample;
    assign samp[2] = ext2_sample;

    // ----------------------------------------
    // Channel datapath
    // ----------------------------------------
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        // RULE1 RULE2 RULE3 RULE11: selected count, gated
        ttm_averager #(
            .WIDTH (WIDTH),
            .CNT_W (5)
        ) u_avg (
            .hclk    (hclk),
            .hresetn (hresetn),
            .enable  (en_q[c]),
            .avg_sel (avgcfg_q[2*c +: 2]),
            .sample  (samp[c]),
            .result  (res[c])
        );

        // RULE10 RULE12: signed compare per average
        ttm_limit_check #(
            .WIDTH (WIDTH)
        ) u_chk (
            .hclk       (hclk),
            .hresetn    (hresetn),
            .result     (res[c]),
            .high_limit (hi_q[c]),
            .low_limit  (lo_q[c]),
            .over       (over[c]),
            .under      (under[c]),
            .eval       (eval[c])
        );

        // Events fire only on a fresh evaluation
        assign over_seen[c]  = eval[c] & over[c];
        assign under_seen[c] = eval[c] & under[c];
    end

    // ----------------------------------------
    // Live status word, nibble per channel
    // ----------------------------------------
    // Latest compare only, not sticky; bits 0 and 3
    // of each nibble always read as zero
    always_comb begin
        status_w = 12'h000;
        for (int i = 0; i < NCH; i++) begin
            // RULE4 RULE6 RULE8: high compare bit
            status_w[`TTM_STAT_STRIDE*i+`TTM_STAT_HIGH_BIT] = over[i];
            // RULE5 RULE7 RULE9: low compare bit
            status_w[`TTM_STAT_STRIDE*i+`TTM_STAT_LOW_BIT]  = under[i];
        end
    end

    // ----------------------------------------
    // Register read mux
    // ----------------------------------------
    always_comb begin
        rd_addr = addr_q;
        rd_mux  = 32'h0000_0000;
        unique case (rd_addr)
            `TTM_OFF_AVGCFG:   rd_mux = {26'h0, avgcfg_q};
            `TTM_OFF_INT_HI:   rd_mux = {20'h0, hi_q[0]};
            `TTM_OFF_INT_LO:   rd_mux = {20'h0, lo_q[0]};
            `TTM_OFF_EXT1_HI:  rd_mux = {20'h0, hi_q[1]};
            `TTM_OFF_EXT1_LO:  rd_mux = {20'h0, lo_q[1]};
            `TTM_OFF_EXT2_HI:  rd_mux = {20'h0, hi_q[2]};
            `TTM_OFF_EXT2_LO:  rd_mux = {20'h0, lo_q[2]};
            `TTM_OFF_ENABLES:  rd_mux = {29'h0, en_q};
            // Live compare outcome, nibble per channel
            `TTM_OFF_STATUS:   rd_mux = {20'h0, status_w};
            `TTM_OFF_IRQ_STAT: rd_mux = {26'h0, istat_q};
            `TTM_OFF_IRQ_MASK: rd_mux = {26'h0, imask_q};
            `TTM_OFF_RESULT0:  rd_mux = {20'h0, last_q[0]};
            `TTM_OFF_RESULT1:  rd_mux = {20'h0, last_q[1]};
            `TTM_OFF_RESULT2:  rd_mux = {20'h0, last_q[2]};
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------
    // Bus pipeline next state
    // ----------------------------------------
    // Only an accepted address phase moves the pipeline;
    // the read wait state blocks a new one, so a read
    // and a write never share a data phase
    always_comb begin
        addr_ok = hsel & hready & htrans[1];
        bst_d   = addr_ok ? TTM_DATA : TTM_IDLE;
        wr_d    = addr_ok & hwrite;
        addr_d  = addr_ok ? {haddr[11:2], 2'b00} : addr_q;
        rdata_d = rdata_q;
        // Read data registered one cycle ahead
        if (bst_q == TTM_DATA && !wr_q) begin
            rdata_d = rd_mux;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bst_q   <= TTM_IDLE;
            wr_q    <= 1'b0;
            addr_q  <= 12'h000;
            rdata_q <= 32'h0000_0000;
        end else begin
            bst_q   <= bst_d;
            wr_q    <= wr_d;
            addr_q  <= addr_d;
            rdata_q <= rdata_d;
        end
    end

    // Write data phase, one cycle per accepted write
    assign wr_dp = (bst_q == TTM_DATA) && wr_q;

    // ----------------------------------------
    // Configuration, limits and last averages
    // ----------------------------------------
    // Writes to unmapped offsets fall through and are lost;
    // the interrupt status and mask words are handled below
    always_comb begin
        avgcfg_d = avgcfg_q;
        en_d     = en_q;
        for (int i = 0; i < NCH; i++) begin
            hi_d[i]   = hi_q[i];
            lo_d[i]   = lo_q[i];
            last_d[i] = res[i].done ? res[i].temp : last_q[i];
        end
        if (wr_dp) begin
            unique case (addr_q)
                // RULE1 RULE2 RULE3: count fields
                `TTM_OFF_AVGCFG:  avgcfg_d = hwdata[5:0];
                // RULE10: signed limit words
                `TTM_OFF_INT_HI:  hi_d[0]  = hwdata[WIDTH-1:0];
                `TTM_OFF_INT_LO:  lo_d[0]  = hwdata[WIDTH-1:0];
                `TTM_OFF_EXT1_HI: hi_d[1]  = hwdata[WIDTH-1:0];
                `TTM_OFF_EXT1_LO: lo_d[1]  = hwdata[WIDTH-1:0];
                `TTM_OFF_EXT2_HI: hi_d[2]  = hwdata[WIDTH-1:0];
                `TTM_OFF_EXT2_LO: lo_d[2]  = hwdata[WIDTH-1:0];
                // RULE11: channel enable bits
                `TTM_OFF_ENABLES: en_d     = hwdata[NCH-1:0];
                default:          ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            avgcfg_q <= `TTM_RST_AVGCFG;
            en_q     <= `TTM_RST_ENABLES;
            // Limits start at the extremes, so nothing trips
            for (int i = 0; i < NCH; i++) begin
                hi_q[i]   <= `TTM_RST_HI_LIMIT;
                lo_q[i]   <= `TTM_RST_LO_LIMIT;
                last_q[i] <= 12'h000;
            end
        end else begin
            avgcfg_q <= avgcfg_d;
            en_q     <= en_d;
            for (int i = 0; i < NCH; i++) begin
                hi_q[i]   <= hi_d[i];
                lo_q[i]   <= lo_d[i];
                last_q[i] <= last_d[i];
            end
        end
    end

    // ----------------------------------------
    // Interrupt status, mask and line
    // ----------------------------------------
    // Sticky events, cleared by writing ones; the mask
    // only gates the line, never the events themselves
    always_comb begin
        imask_d = imask_q;
        istat_d = istat_q;
        if (wr_dp && addr_q == `TTM_OFF_IRQ_MASK) begin
            imask_d = hwdata[5:0];
        end
        // Clear applied first, so a same-cycle event wins
        if (wr_dp && addr_q == `TTM_OFF_IRQ_STAT) begin
            istat_d = istat_q & ~hwdata[5:0];
        end
        for (int i = 0; i < NCH; i++) begin
            // RULE4 RULE6 RULE8: high crossing latched
            if (over_seen[i]) begin
                istat_d[2*i+1] = 1'b1;
            end
            // RULE5 RULE7 RULE9: low crossing latched
            if (under_seen[i]) begin
                istat_d[2*i] = 1'b1;
            end
        end
        // Follows the next status, so the line is not a cycle late
        irq_d = |(istat_d & imask_d);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            istat_q <= 6'h00;
            imask_q <= 6'h00;
            irq_q   <= 1'b0;
        end else begin
            istat_q <= istat_d;
            imask_q <= imask_d;
            irq_q   <= irq_d;
        end
    end

    // ----------------------------------------
    // Bus handshake outputs
    // ----------------------------------------
    // Read data trails by a wait state, so stretch;
    // writes never stall, the register takes hwdata
    // at the end of their single data phase
    logic hrdy_q, hrdy_d;
    always_comb begin
        hrdy_d = !(addr_ok && !hwrite);
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdy_q <= 1'b1;
        end else begin
            hrdy_q <= hrdy_d;
        end
    end

    // Every access answers OKAY; kept in a flop so
    // that all output pins leave registers
    logic hresp_q, hresp_d;
    always_comb begin
        hresp_d = 1'b0;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp_q <= 1'b0;
        end else begin
            hresp_q <= hresp_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign hrdata    = rdata_q;
    assign hreadyout = hrdy_q;
    assign hresp     = hresp_q;
    assign irq       = irq_q;
endmodule
`default_nettype wire

// *** bench/ttm_monitor_props.sv ***
`default_nettype none
`include "ttm_map.svh"
module ttm_monitor_props (
    input wire logic                 hclk,
    input wire logic                 hresetn,
    input wire logic                 hsel,
    input wire logic [31:0]          haddr,
    input wire logic [1:0]           htrans,
    input wire logic                 hwrite,
    input wire logic [2:0]           hsize,
    input wire logic [31:0]          hwdata,
    input wire logic                 hready,
    input wire logic [31:0]          hrdata,
    input wire logic                 hreadyout,
    input wire logic                 hresp,
    input wire ttm_pkg::ttm_sample_s int_sample,
    input wire ttm_pkg::ttm_sample_s ext1_sample,
    input wire ttm_pkg::ttm_sample_s ext2_sample,
    input wire logic                 irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        rd_dp_q;
    logic        wr_dp_q;
    logic [11:0] a_q;
    logic        rd_done;
    logic        anyv;
    logic        req;

    // Data phase tracking, held while the slave stalls
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_dp_q <= 1'b0;
            wr_dp_q <= 1'b0;
            a_q     <= 12'h000;
        end else if (hready) begin
            rd_dp_q <= req && !hwrite;
            wr_dp_q <= req && hwrite;
            a_q     <= haddr[11:0];
        end
    end
    assign req = hsel && htrans[1];
    assign rd_done = rd_dp_q && hreadyout;
    assign anyv = int_sample.valid || ext1_sample.valid || ext2_sample.valid;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("error response seen");
    property p_rd_wait; req && hready && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    property p_wr_ready; req && hready && hwrite |=> hreadyout; endproperty
    a_wr_ready: assert property (p_wr_ready) else $error("write stalled");
    property p_cfg_rd; rd_done && a_q == `TTM_OFF_AVGCFG |-> hrdata[31:6] == 26'h0; endproperty
    a_cfg_rd: assert property (p_cfg_rd) else $error("config read too wide");
    property p_lim_rd;
        rd_done && a_q inside {[12'h004:12'h018]} |-> hrdata[31:12] == 20'h0;
    endproperty
    a_lim_rd: assert property (p_lim_rd) else $error("limit read too wide");
    property p_en_rd; rd_done && a_q == `TTM_OFF_ENABLES |-> hrdata[31:3] == 29'h0; endproperty
    a_en_rd: assert property (p_en_rd) else $error("enable read too wide");
    property p_stat_rd;
        rd_done && a_q == `TTM_OFF_STATUS |-> (hrdata & 32'hfffff999) == 32'h0;
    endproperty
    a_stat_rd: assert property (p_stat_rd) else $error("status stray bits");
    property p_unmap; rd_done && a_q >= 12'h038 |-> hrdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
    property p_rd_hold; $changed(hrdata) |-> rd_done; endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved outside a read");
    // Interrupt may only rise after a sample or a register write
    property p_irq_rise;
        $rose(irq) |-> $past(anyv, 3) || $past(anyv, 4) || $past(wr_dp_q)
            || $past(wr_dp_q, 2) || $past(wr_dp_q, 3);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose uncaused");
    property p_irq_fall;
        $fell(irq) |-> $past(wr_dp_q) || $past(wr_dp_q, 2) || $past(wr_dp_q, 3);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell uncaused");
endmodule
bind ttm_monitor ttm_monitor_props ttm_monitor_props_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .int_sample(int_sample),
    .ext1_sample(ext1_sample), .ext2_sample(ext2_sample), .irq(irq)
);
`default_nettype wire

// *** bench/ttm_monitor_test.sv ***
`default_nettype none
`include "ttm_map.svh"
module ttm_monitor_test;
    timeunit 1ns;
    timeprecision 1ns;
    import ttm_pkg::*;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hrdy;
    logic        hresp;
    logic        irq;
    ttm_sample_s smp [3];
    logic [31:0] r;
    int          err_total = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          n;
    // Per code: just over high, equal to high, just under low, negative in band
    logic [11:0] vt [4] = '{12'h011, 12'h010, 12'hfdf, 12'hff8};
    logic [1:0]  et [4] = '{2'b10, 2'b00, 2'b01, 2'b00};

    ttm_monitor ttm_monitor_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
        .hreadyout(hrdy), .hresp(hresp), .int_sample(smp[0]), .ext1_sample(smp[1]),
        .ext2_sample(smp[2]), .irq(irq)
    );

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // Hang guard, well above the expected run length
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end

    task automatic test_done();
        if (err_total == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Single word transfer; the slave decides the wait
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hrdy !== 1'b1);
        r = hrdata;
    endtask

    task automatic feed(input int ch, input logic [11:0] v, input int k);
        for (int i = 0; i < k; i++) begin
            @(posedge hclk);
            smp[ch] <= '{1'b1, v};
        end
        @(posedge hclk);
        smp[ch] <= '0;
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        smp = '{default: '0};
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        // Reset values of the writable registers
        for (int a = 0; a <= 'h28; a += 4) begin
            xfer(1'b0, 12'(a), 32'h0);
            chk("reset value", r, (a == 0 || a >= 'h1c) ? 32'h0 : a[2] ? 32'h7ff : 32'h800);
        end
        xfer(1'b1, 12'h040, 32'hffffffff);
        xfer(1'b0, 12'h040, 32'h0);
        chk("unmapped", r, 32'h0);
        xfer(1'b1, `TTM_OFF_IRQ_MASK, 32'h3f);
        for (int ch = 0; ch < 3; ch++) begin
            // Upper bits written high must be dropped
            xfer(1'b1, `TTM_OFF_INT_HI + 12'(8 * ch), 32'hfffff010);
            xfer(1'b1, `TTM_OFF_INT_LO + 12'(8 * ch), 32'h00000fe0);
            xfer(1'b0, `TTM_OFF_INT_HI + 12'(8 * ch), 32'h0);
            chk("high limit", r, 32'h010);
            xfer(1'b1, `TTM_OFF_ENABLES, 32'(1 << ch));
            for (int c = 0; c < 4; c++) begin
                n = 4 << c;
                xfer(1'b1, `TTM_OFF_AVGCFG, 32'(c << (2 * ch)));
                feed(ch, vt[c] - 12'h4, n / 2);
                feed(ch, vt[c] + 12'h4, n / 2 - 1);
                repeat (6) @(posedge hclk);
                chk("early irq", 32'(irq), 32'h0);
                feed(ch, vt[c] + 12'h4, 1);
                xfer(1'b0, `TTM_OFF_STATUS, 32'h0);
                chk("status", 32'(r[4*ch+:4]), {29'h0, et[c], 1'b0});
                xfer(1'b0, `TTM_OFF_RESULT0 + 12'(4 * ch), 32'h0);
                chk("average", 32'(r[11:0]), 32'(vt[c]));
                xfer(1'b0, `TTM_OFF_IRQ_STAT, 32'h0);
                chk("events", r, 32'(et[c]) << (2 * ch));
                chk("irq", 32'(irq), 32'(et[c] != 2'b00));
                xfer(1'b1, `TTM_OFF_IRQ_MASK, 32'h0);
                repeat (2) @(posedge hclk);
                chk("masked irq", 32'(irq), 32'h0);
                xfer(1'b1, `TTM_OFF_IRQ_MASK, 32'h3f);
                xfer(1'b1, `TTM_OFF_IRQ_STAT, 32'h3f);
                repeat (2) @(posedge hclk);
                chk("cleared irq", 32'(irq), 32'h0);
            end
        end
        // Samples on a disabled channel are dropped
        xfer(1'b1, `TTM_OFF_ENABLES, 32'h0);
        feed(0, 12'h100, 4);
        xfer(1'b0, `TTM_OFF_RESULT0, 32'h0);
        chk("disabled", 32'(r[11:0]), 32'hff8);
        chk("disabled irq", 32'(irq), 32'h0);
        // Disabling mid-average must drop the partial sum
        xfer(1'b1, `TTM_OFF_ENABLES, 32'h1);
        feed(0, 12'h100, 2);
        xfer(1'b1, `TTM_OFF_ENABLES, 32'h0);
        xfer(1'b1, `TTM_OFF_ENABLES, 32'h1);
        feed(0, 12'h020, 4);
        xfer(1'b0, `TTM_OFF_RESULT0, 32'h0);
        chk("partial dropped", 32'(r[11:0]), 32'h020);
        test_done();
    end
endmodule
`default_nettype wire
